// >>> hdl/agp_ports.sv
// Analog-shared port and two open-drain-capable GPIO ports
//
// Functional notes
// - Reset: mixed dir, latch clear, conversion disabled
// - Direction 1 drives latch regardless of converter
// - Clear bits, then enable converter; conversion starts
// - Channel field alone picks converted pin
// - Input bit with latch 0 reads 0
// - Read-modify-write reads latch on output bits, pin gated by latch on inputs, rewrites all latches
// - Reset: port A dir and latch clear
// - Port A bits follow own direction bit
// - Port A drain select, resets to tri-state
// - Reset: port B dir and latch clear
// - Port B bits follow own direction bit
// - Port B drain select, resets to tri-state
// - Open-drain RMW reads latch, else pin
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

module agp_ports
(
   input  wire logic                          ref_clk_in,     // Clock
   input  wire logic                          sys_rst_in,     // Sync reset
   input  wire logic [agp_pkg::ADDR_W-1:0]    reg_addr_in,    // Address
   input  wire logic [agp_pkg::DATA_W-1:0]    reg_wdata_in,   // Write data
   input  wire logic                          reg_wr_in,      // Write strobe
   input  wire logic                          reg_rd_in,      // Read strobe
   input  wire logic                          reg_rmw_in,     // Read is RMW
   output logic [agp_pkg::DATA_W-1:0]         reg_rdata_out,  // Read data
   input  wire logic [agp_pkg::DATA_W-1:0]    mix_pin_in,     // Mixed pins
   output logic [agp_pkg::DATA_W-1:0]         mix_pin_out,    // Mixed level
   output logic [agp_pkg::DATA_W-1:0]         mix_pin_oe_out, // Mixed enable
   input  wire logic [agp_pkg::NUM_OD-1:0][agp_pkg::DATA_W-1:0]
                                              od_pin_in,      // OD pins
   output logic [agp_pkg::NUM_OD-1:0][agp_pkg::DATA_W-1:0]
                                              od_pin_out,     // OD level
   output logic [agp_pkg::NUM_OD-1:0][agp_pkg::DATA_W-1:0]
                                              od_pin_oe_out,  // OD enable
   input  wire logic                          debug_src_in,   // Debug source
   output logic [agp_pkg::DATA_W-1:0]         analog_sel_out, // Chan select
   output logic                               conv_start_out, // Start pulse
   output logic                               conv_dis_out    // Conv off
);

   // ------------------------------------------------------------------
   // Decode helper
   // ------------------------------------------------------------------
   function automatic logic addr_hit
   (
      input logic                       strobe,
      input logic [agp_pkg::ADDR_W-1:0] addr,
      input logic [agp_pkg::ADDR_W-1:0] target
   );
      addr_hit = strobe && (addr == target);
   endfunction : addr_hit

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   logic [agp_pkg::DATA_W-1:0] mix_latch_q;
   logic [agp_pkg::DATA_W-1:0] mix_latch_d;
   logic [agp_pkg::DATA_W-1:0] mix_dir_q;
   logic [agp_pkg::DATA_W-1:0] mix_dir_d;
   logic [agp_pkg::CHAN_W-1:0] chan_q;
   logic [agp_pkg::CHAN_W-1:0] chan_d;
   logic                       conv_dis_q;
   logic                       conv_dis_d;
   logic                       dbg_en_q;
   logic                       dbg_en_d;
   logic                       conv_start_q;
   logic                       conv_start_d;
   logic [agp_pkg::DATA_W-1:0] analog_sel_q;
   logic [agp_pkg::DATA_W-1:0] analog_sel_d;
   logic [agp_pkg::DATA_W-1:0] rdata_q;
   logic [agp_pkg::DATA_W-1:0] rdata_d;
   logic [agp_pkg::DATA_W-1:0] rd_mux;
   agp_pkg::agp_pin_drv_t      mix_drv_q;
   agp_pkg::agp_pin_drv_t      mix_drv_d;
   agp_pkg::agp_od_regs_t      od_q     [agp_pkg::NUM_OD];
   agp_pkg::agp_od_regs_t      od_d     [agp_pkg::NUM_OD];
   agp_pkg::agp_pin_drv_t      od_drv_q [agp_pkg::NUM_OD];
   agp_pkg::agp_pin_drv_t      od_drv_d [agp_pkg::NUM_OD];
   logic [agp_pkg::DATA_W-1:0] od_rd_val [agp_pkg::NUM_OD];
   logic [agp_pkg::DATA_W-1:0] mix_rd_val;
   logic [agp_pkg::DATA_W-1:0] conv_ctrl_val;
   logic [agp_pkg::DATA_W-1:0] dbg_ctrl_val;
   logic                       wr_mix_latch;
   logic                       wr_mix_dir;
   logic                       wr_conv;
   logic                       wr_dbg;

   // ------------------------------------------------------------------
   // Mixed port and converter control
   // ------------------------------------------------------------------

   // Write decode
   assign wr_mix_latch = addr_hit(reg_wr_in, reg_addr_in,
                                  agp_pkg::MIX_LATCH_ADDR);
   assign wr_mix_dir   = addr_hit(reg_wr_in, reg_addr_in,
                                  agp_pkg::MIX_DIR_ADDR);
   assign wr_conv      = addr_hit(reg_wr_in, reg_addr_in,
                                  agp_pkg::CONV_CTRL_ADDR);
   assign wr_dbg       = addr_hit(reg_wr_in, reg_addr_in,
                                  agp_pkg::DEBUG_CTRL_ADDR);

   // Next register values
   assign mix_latch_d = wr_mix_latch ? reg_wdata_in : mix_latch_q;
   assign mix_dir_d   = wr_mix_dir ? reg_wdata_in : mix_dir_q;
   assign chan_d      = wr_conv ?
      reg_wdata_in[agp_pkg::CHAN_LSB +: agp_pkg::CHAN_W] : chan_q;
   assign conv_dis_d  = wr_conv ?
      reg_wdata_in[agp_pkg::CONV_DIS_BIT] : conv_dis_q;
   assign dbg_en_d    = wr_dbg ?
      reg_wdata_in[agp_pkg::DEBUG_EN_BIT] : dbg_en_q;

   // Start pulse when the converter is switched on
   assign conv_start_d = conv_dis_q & ~conv_dis_d;

   // Pin drive: direction 1 drives the latch, debug gated on bit 7
   always_comb
   begin
      mix_drv_d.oe  = mix_dir_q;
      mix_drv_d.out = mix_dir_q & mix_latch_q;
      if (dbg_en_q)
      begin
         mix_drv_d.out[agp_pkg::DEBUG_PIN] =
            mix_dir_q[agp_pkg::DEBUG_PIN] &
            mix_latch_q[agp_pkg::DEBUG_PIN] & debug_src_in;
      end
   end

   // Converted pin chosen by channel field only
   generate
      for (genvar i = 0; i < agp_pkg::DATA_W; i++)
      begin : g_sel
         assign analog_sel_d[i] = ~conv_dis_q &
            (chan_q == agp_pkg::CHAN_W'(agp_pkg::MIX_CHAN_BASE + i));
      end
   endgenerate

   // Output bits read latch; input bits read pin gated by latch
   assign mix_rd_val = mix_latch_q & (mix_dir_q | mix_pin_in);

   // Control readback
   always_comb
   begin
      conv_ctrl_val = agp_pkg::READ_IDLE;
      conv_ctrl_val[agp_pkg::CHAN_LSB +: agp_pkg::CHAN_W] = chan_q;
      conv_ctrl_val[agp_pkg::CONV_DIS_BIT] = conv_dis_q;
      dbg_ctrl_val = agp_pkg::READ_IDLE;
      dbg_ctrl_val[agp_pkg::DEBUG_EN_BIT] = dbg_en_q;
   end

   // Mixed port and converter registers
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         mix_latch_q  <= agp_pkg::PORT_RST;
         mix_dir_q    <= agp_pkg::PORT_RST;
         chan_q       <= agp_pkg::CHAN_RST;
         conv_dis_q   <= 1'b1;
         dbg_en_q     <= 1'b0;
         conv_start_q <= 1'b0;
         analog_sel_q <= agp_pkg::PORT_RST;
         mix_drv_q    <= '0;
      end
      else
      begin
         mix_latch_q  <= mix_latch_d;
         mix_dir_q    <= mix_dir_d;
         chan_q       <= chan_d;
         conv_dis_q   <= conv_dis_d;
         dbg_en_q     <= dbg_en_d;
         conv_start_q <= conv_start_d;
         analog_sel_q <= analog_sel_d;
         mix_drv_q    <= mix_drv_d;
      end
   end

   // ------------------------------------------------------------------
   // Open-drain-capable ports
   // ------------------------------------------------------------------
   generate
      for (genvar p = 0; p < agp_pkg::NUM_OD; p++)
      begin : g_od
         // Per-port write decode and next values
         assign od_d[p].latch = addr_hit(reg_wr_in, reg_addr_in,
            agp_pkg::OD_LATCH_ADDR[p]) ? reg_wdata_in : od_q[p].latch;
         assign od_d[p].dir   = addr_hit(reg_wr_in, reg_addr_in,
            agp_pkg::OD_DIR_ADDR[p]) ? reg_wdata_in : od_q[p].dir;
         assign od_d[p].ode   = addr_hit(reg_wr_in, reg_addr_in,
            agp_pkg::OD_ODE_ADDR[p]) ? reg_wdata_in : od_q[p].ode;

         // Open-drain releases on 1, tri-state drives both levels
         assign od_drv_d[p].oe  = od_q[p].dir &
            (~od_q[p].ode | ~od_q[p].latch);
         assign od_drv_d[p].out = od_q[p].latch & ~od_q[p].ode;

         // RMW sees latch on open-drain bits, else the pin
         assign od_rd_val[p] = reg_rmw_in ?
            ((od_q[p].ode & od_q[p].latch) |
             (~od_q[p].ode & od_pin_in[p])) : od_pin_in[p];

         // Port registers, all clear on reset
         always_ff @(posedge ref_clk_in)
         begin
            if (sys_rst_in)
            begin
               od_q[p]     <= '0;
               od_drv_q[p] <= '0;
            end
            else
            begin
               od_q[p]     <= od_d[p];
               od_drv_q[p] <= od_drv_d[p];
            end
         end

         assign od_pin_out[p]    = od_drv_q[p].out;
         assign od_pin_oe_out[p] = od_drv_q[p].oe;
      end
   endgenerate

   // ------------------------------------------------------------------
   // Register read path
   // ------------------------------------------------------------------

   // Read select, unmapped reads return zero; input bits read pins, gated by latch on the mixed port
   always_comb
   begin
      rd_mux = agp_pkg::READ_IDLE;
      if (reg_addr_in == agp_pkg::MIX_LATCH_ADDR)
         rd_mux = mix_rd_val;
      else if (reg_addr_in == agp_pkg::MIX_DIR_ADDR)
         rd_mux = mix_dir_q;
      else if (reg_addr_in == agp_pkg::CONV_CTRL_ADDR)
         rd_mux = conv_ctrl_val;
      else if (reg_addr_in == agp_pkg::DEBUG_CTRL_ADDR)
         rd_mux = dbg_ctrl_val;
      else
      begin
         for (int p = 0; p < agp_pkg::NUM_OD; p++)
         begin
            if (reg_addr_in == agp_pkg::OD_LATCH_ADDR[p])
               rd_mux = od_rd_val[p];
            else if (reg_addr_in == agp_pkg::OD_DIR_ADDR[p])
               rd_mux = od_q[p].dir;
            else if (reg_addr_in == agp_pkg::OD_ODE_ADDR[p])
               rd_mux = od_q[p].ode;
         end
      end
   end

   // Data stand only in the cycle after the strobe
   assign rdata_d = reg_rd_in ? rd_mux : agp_pkg::READ_IDLE;

   // Read data register
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         rdata_q <= agp_pkg::READ_IDLE;
      else
         rdata_q <= rdata_d;
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign reg_rdata_out  = rdata_q;
   assign mix_pin_out    = mix_drv_q.out;
   assign mix_pin_oe_out = mix_drv_q.oe;
   assign analog_sel_out = analog_sel_q;
   assign conv_start_out = conv_start_q;
   assign conv_dis_out   = conv_dis_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_conv_on;
      $fell(conv_dis_q);
   endsequence

   sequence s_start_pulse;
      conv_start_q ##1 !conv_start_q;
   endsequence

   a_reset_mixed_clear : assert property (
      disable iff (1'b0)
      sys_rst_in |=> (mix_dir_q == 8'h00) && (mix_latch_q == 8'h00)
                     && conv_dis_q ##1 (mix_pin_oe_out == 8'h00))
      else $error("mixed port not cleared by reset");

   a_reset_od_clear : assert property (
      disable iff (1'b0)
      sys_rst_in |=> (od_q[0] == '0) && (od_q[1] == '0)
                     ##1 (od_pin_oe_out == '0))
      else $error("open-drain ports not cleared by reset");

   a_mixed_out_drive : assert property (
      mix_pin_oe_out == $past(mix_dir_q) &&
      ((mix_pin_out & ~$past(mix_latch_q)) == 8'h00))
      else $error("mixed pin enable or level wrong");

   a_conv_start_pulse : assert property (
      s_conv_on |-> s_start_pulse)
      else $error("conversion start pulse missing");

   a_chan_select_only : assert property (
      ##1 $onehot0(analog_sel_out) &&
      ((analog_sel_out != 8'h00) == (!$past(conv_dis_q) &&
       $past(chan_q) >= 4'h8)))
      else $error("analog channel select wrong");

   a_mixed_read_zero : assert property (
      (reg_rd_in && reg_addr_in == agp_pkg::MIX_LATCH_ADDR) |=>
      ((reg_rdata_out & ~$past(mix_dir_q) & ~$past(mix_latch_q))
       == 8'h00))
      else $error("input bit with clear latch read nonzero");

   a_read_one_cycle : assert property (
      !reg_rd_in |=> (reg_rdata_out == 8'h00))
      else $error("read data stood outside its cycle");

   generate
      for (genvar p = 0; p < agp_pkg::NUM_OD; p++)
      begin : g_od_chk
         a_od_enable : assert property (
            od_pin_oe_out[p] == ($past(od_q[p].dir) &
               (~$past(od_q[p].ode) | ~$past(od_q[p].latch))))
            else $error("open-drain port enable wrong");

         a_od_low_only : assert property (
            ((od_pin_out[p] & od_pin_oe_out[p] &
              $past(od_q[p].ode)) == 8'h00))
            else $error("open-drain bit drove high");

         a_od_rmw_read : assert property (
            (reg_rd_in && reg_addr_in == agp_pkg::OD_LATCH_ADDR[p]) |=>
            (((reg_rdata_out ^ $past(od_q[p].latch)) &
              $past(od_q[p].ode) & {8{$past(reg_rmw_in)}}) == 8'h00) &&
            (((reg_rdata_out ^ $past(od_pin_in[p])) &
              ~($past(od_q[p].ode) & {8{$past(reg_rmw_in)}})) == 8'h00))
            else $error("open-drain port read source wrong");
      end
   endgenerate

endmodule : agp_ports

// >>> hdl/agp_pkg.sv
// Constants, register map and carrier types of the shared GPIO ports
package agp_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int NUM_OD = 2;

   // ------------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] MIX_LATCH_ADDR  = 13'h0007;
   localparam logic [ADDR_W-1:0] MIX_DIR_ADDR    = 13'h1f8d;
   localparam logic [ADDR_W-1:0] CONV_CTRL_ADDR  = 13'h1f90;
   localparam logic [ADDR_W-1:0] DEBUG_CTRL_ADDR = 13'h1f91;
   // Index 0 is open-drain port A, index 1 is port B
   localparam logic [NUM_OD-1:0][ADDR_W-1:0] OD_LATCH_ADDR =
      {13'h0009, 13'h0008};
   localparam logic [NUM_OD-1:0][ADDR_W-1:0] OD_ODE_ADDR =
      {13'h1f87, 13'h1f86};
   localparam logic [NUM_OD-1:0][ADDR_W-1:0] OD_DIR_ADDR =
      {13'h1f8f, 13'h1f8e};

   // ------------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------------
   localparam int CHAN_LSB      = 0;
   localparam int CHAN_W        = 4;
   localparam int CONV_DIS_BIT  = 4;
   localparam int DEBUG_EN_BIT  = 0;
   localparam int DEBUG_PIN     = 7;
   localparam int MIX_CHAN_BASE = 8;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [DATA_W-1:0] PORT_RST      = 8'h00;
   localparam logic [DATA_W-1:0] READ_IDLE     = 8'h00;
   localparam logic [CHAN_W-1:0] CHAN_RST      = 4'h0;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] latch;
      logic [DATA_W-1:0] dir;
      logic [DATA_W-1:0] ode;
   } agp_od_regs_t;

   typedef struct packed {
      logic [DATA_W-1:0] out;
      logic [DATA_W-1:0] oe;
   } agp_pin_drv_t;

endpackage : agp_pkg

// >>> bench/agp_pin_model.sv
// Pin-side model: external drivers and pull-ups on one 8-bit port
`timescale 1ns/1ps

module agp_pin_model
(
   input  wire logic [7:0] drv_out_in,  // Device drive level
   input  wire logic [7:0] drv_oe_in,   // Device drive enable
   input  wire logic [7:0] ext_val_in,  // External drive level
   input  wire logic [7:0] ext_en_in,   // External drive enable
   output logic      [7:0] level_out,   // Resolved pin level
   output logic            conflict_out // Both sides drive a pin
);
   // ---------------------------------------------------------------
   // Wire resolution
   // ---------------------------------------------------------------
   // Released pins with no external driver float up to the pull-up level
   assign level_out = (drv_oe_in & drv_out_in)
                    | (~drv_oe_in & ext_en_in & ext_val_in)
                    | (~drv_oe_in & ~ext_en_in);
   // Contention when an output meets an external driver
   assign conflict_out = |(drv_oe_in & ext_en_in);
endmodule : agp_pin_model

// >>> bench/tb_agp_ports.sv
// Self-checking bench for the shared and open-drain GPIO ports
`timescale 1ns/1ps

module tb_agp_ports;
   localparam int AW = agp_pkg::ADDR_W;
   logic            clk = 1'h0;
   logic            rst = 1'h1;
   logic [AW-1:0]   addr = 13'h0000;
   logic [7:0]      wdata = 8'h00;
   logic            wr_s = 1'h0;
   logic            rd_s = 1'h0;
   logic            rmw = 1'h0;
   logic            dbg = 1'h0;
   logic [7:0]      rdata, mix_in, mix_out, mix_oe, sel;
   logic [1:0][7:0] od_in, od_out, od_oe;
   logic            start, dis;
   logic [2:0][7:0] ext_val = 24'h5ac3a5;
   logic [2:0][7:0] ext_en = 24'hffffff;
   logic [2:0][7:0] level, drv_out, drv_oe;
   logic [2:0]      conflict;
   logic [7:0]      d, l, c, v;
   int              num_errors = 0;
   int              checks_done = 0;
   int              pulses = 0;
   int              n;

   // ---------------------------------------------------------------
   // Clock, design and pin models
   // ---------------------------------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) if (start === 1'h1) pulses <= pulses + 1;

   agp_ports u_agp_ports (.ref_clk_in(clk), .sys_rst_in(rst),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
      .reg_rd_in(rd_s), .reg_rmw_in(rmw), .reg_rdata_out(rdata),
      .mix_pin_in(mix_in), .mix_pin_out(mix_out),
      .mix_pin_oe_out(mix_oe), .od_pin_in(od_in), .od_pin_out(od_out),
      .od_pin_oe_out(od_oe), .debug_src_in(dbg), .analog_sel_out(sel),
      .conv_start_out(start), .conv_dis_out(dis));

   // Slot 0 is the mixed port, slots 1 and 2 the open-drain ports
   assign drv_out = {od_out, mix_out};
   assign drv_oe  = {od_oe, mix_oe};
   for (genvar g = 0; g < 3; g++)
   begin : g_pin
      agp_pin_model u_agp_pin_model (
         .drv_out_in(drv_out[g]),
         .drv_oe_in(drv_oe[g]),
         .ext_val_in(ext_val[g]), .ext_en_in(ext_en[g]),
         .level_out(level[g]), .conflict_out(conflict[g]));
   end
   assign mix_in = level[0];
   assign od_in  = level[2:1];

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   task automatic wr(input logic [AW-1:0] a, input logic [7:0] dv);
      @(posedge clk);
      wr_s <= 1'h1;
      addr <= a;
      wdata <= dv;
      @(posedge clk);
      wr_s <= 1'h0;
   endtask : wr

   task automatic rd(input logic [AW-1:0] a, input logic m,
                     output logic [7:0] rv);
      @(posedge clk);
      rd_s <= 1'h1;
      addr <= a;
      rmw <= m;
      @(posedge clk);
      rd_s <= 1'h0;
      rmw <= 1'h0;
      #1 rv = rdata;
   endtask : rd

   task automatic settle();
      repeat (3) @(posedge clk);
      #1 chk({5'h00, conflict}, 8'h00);
   endtask : settle

   function automatic logic [7:0] f_level(input logic [7:0] oe, dv, en,
                                          ev);
      return (oe & dv) | (~oe & en & ev) | (~oe & ~en);
   endfunction : f_level

   function automatic logic [7:0] f_sel(input logic [7:0] cv);
      return (!cv[4] && cv[3]) ? (8'h01 << cv[2:0]) : 8'h00;
   endfunction : f_sel

   // Register and pin state straight after a reset
   task automatic reset_check();
      logic [7:0] rv;
      @(posedge clk);
      #1 chk({7'h00, dis}, 8'h01);
      chk(mix_oe, 8'h00);
      chk(od_oe[0], 8'h00);
      chk(od_oe[1], 8'h00);
      chk(sel, 8'h00);
      rd(agp_pkg::MIX_DIR_ADDR, 1'h0, rv);
      chk(rv, 8'h00);
      rd(agp_pkg::MIX_LATCH_ADDR, 1'h0, rv);
      chk(rv, 8'h00);
      rd(agp_pkg::CONV_CTRL_ADDR, 1'h0, rv);
      chk(rv, 8'h10);
      rd(agp_pkg::DEBUG_CTRL_ADDR, 1'h0, rv);
      chk(rv, 8'h00);
      wr(13'h0100, 8'hff);
      rd(13'h0100, 1'h0, rv);
      chk(rv, 8'h00);
      for (int p = 0; p < 2; p++)
      begin
         rd(agp_pkg::OD_DIR_ADDR[p], 1'h0, rv);
         chk(rv, 8'h00);
         rd(agp_pkg::OD_ODE_ADDR[p], 1'h0, rv);
         chk(rv, 8'h00);
         wr(agp_pkg::OD_ODE_ADDR[p], 8'hff);
         rd(agp_pkg::OD_LATCH_ADDR[p], 1'h1, rv);
         chk(rv, 8'h00);
         wr(agp_pkg::OD_ODE_ADDR[p], 8'h00);
      end
   endtask : reset_check

   // Program one open-drain port and check drive and read-back
   task automatic od_run(input int p, input logic [7:0] dv, ov, lv);
      logic [7:0] rv, pl, oe;
      ext_en[p+1] <= ~dv;
      ext_val[p+1] <= 8'($urandom);
      wr(agp_pkg::OD_DIR_ADDR[p], dv);
      wr(agp_pkg::OD_ODE_ADDR[p], ov);
      wr(agp_pkg::OD_LATCH_ADDR[p], lv);
      settle();
      oe = dv & (~ov | ~lv);
      pl = f_level(oe, lv & ~ov, ~dv, ext_val[p+1]);
      chk(od_oe[p], oe);
      chk(od_out[p] & oe, lv & ~ov & oe);
      rd(agp_pkg::OD_LATCH_ADDR[p], 1'h0, rv);
      chk(rv, pl);
      rd(agp_pkg::OD_LATCH_ADDR[p], 1'h1, rv);
      chk(rv, (ov & lv) | (~ov & pl));
      rd(agp_pkg::OD_ODE_ADDR[p], 1'h0, rv);
      chk(rv, ov);
   endtask : od_run

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      n = $urandom(32'h35c2cb91);
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      reset_check();
      od_run(0, 8'hff, 8'hf0, 8'h55);
      od_run(1, 8'h0f, 8'hff, 8'h00);
      for (int i = 0; i < 40; i++)
         od_run(i % 2, 8'($urandom), 8'($urandom), 8'($urandom));
      // Every channel code, analog pins cleared first
      wr(agp_pkg::MIX_DIR_ADDR, 8'h00);
      wr(agp_pkg::MIX_LATCH_ADDR, 8'h00);
      for (int k = 0; k < 16; k++)
      begin
         n = pulses;
         wr(agp_pkg::CONV_CTRL_ADDR, 8'(k));
         settle();
         chk(sel, f_sel(8'(k)));
         chk({7'h00, dis}, 8'h00);
         chk(8'(pulses - n), 8'h01);
         wr(agp_pkg::CONV_CTRL_ADDR, 8'(k) | 8'h10);
         settle();
         chk(sel, 8'h00);
      end
      // Mixed port modes against converter state
      for (int i = 0; i < 30; i++)
      begin
         d = 8'($urandom);
         l = 8'($urandom);
         c = 8'($urandom) & 8'h1f;
         if (!c[4] && c[3])
         begin
            d[c[2:0]] = 1'h0;
            l[c[2:0]] = 1'h0;
         end
         wr(agp_pkg::CONV_CTRL_ADDR, 8'h10);
         ext_en[0] <= ~d;
         ext_val[0] <= 8'($urandom);
         wr(agp_pkg::MIX_DIR_ADDR, d);
         wr(agp_pkg::MIX_LATCH_ADDR, l);
         wr(agp_pkg::CONV_CTRL_ADDR, c);
         settle();
         chk(mix_oe, d);
         chk(mix_out & d, d & l);
         chk(sel, f_sel(c));
         rd(agp_pkg::MIX_LATCH_ADDR, 1'h0, v);
         chk(v, l & (d | f_level(d, d & l, ~d, ext_val[0])));
      end
      // Debug output on bit 7
      wr(agp_pkg::CONV_CTRL_ADDR, 8'h10);
      ext_en[0] <= 8'h7f;
      wr(agp_pkg::MIX_LATCH_ADDR, 8'h80);
      wr(agp_pkg::MIX_DIR_ADDR, 8'h80);
      wr(agp_pkg::DEBUG_CTRL_ADDR, 8'h01);
      for (int i = 0; i < 6; i++)
      begin
         dbg <= (i < 2) ? 1'(i) : 1'($urandom);
         settle();
         chk({7'h00, mix_out[7]}, {7'h00, dbg});
      end
      wr(agp_pkg::DEBUG_CTRL_ADDR, 8'h00);
      // Debug off: bit 7 follows its latch again
      dbg <= 1'h0;
      settle();
      chk({7'h00, mix_out[7]}, 8'h01);
      // Second reset in mid-run
      rst <= 1'h1;
      ext_en <= 24'hffffff;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      reset_check();
      test_done();
   end

   // Watchdog against a hung sequence
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      test_done();
   end
endmodule : tb_agp_ports
